// ==== bench/mct_ext_sig.sv ====
`default_nettype none
module mct_ext_sig #(
  parameter int CNT_PIN = 3,
  parameter int CTL_PIN = 5
) (
  input wire logic sys_clk,
  output logic [7:0] din
);
  timeunit 1ns;
  timeprecision 1ps;
  logic cnt_q;
  logic ctl_q;
  logic [7:0] noise_q;
  initial
  begin
    cnt_q = 1'b0;
    ctl_q = 1'b0;
    noise_q = 8'h55;
  end
  // unselected pins toggle so a wrong pin choice shows
  always @(posedge sys_clk) noise_q <= ~noise_q;
  always_comb
  begin
    din = noise_q;
    din[CNT_PIN] = cnt_q;
    din[CTL_PIN] = ctl_q;
  end
  task automatic pulse(input int hi, input int lo);
    @(posedge sys_clk);
    cnt_q <= 1'b1;
    repeat (hi) @(posedge sys_clk);
    cnt_q <= 1'b0;
    repeat (lo - 1) @(posedge sys_clk);
  endtask
  task automatic set_ctl(input logic v);
    @(posedge sys_clk);
    ctl_q <= v;
  endtask
endmodule // mct_ext_sig
`default_nettype wire

// ==== bench/tb.sv ====
`include "mct_params.svh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk, rst_n, psel, penable, pwrite, pready, pslverr, counter_output;
  logic [7:0] paddr, din, dout;
  logic [31:0] pwdata, prdata;
  int bad_count, tests_run, cyc, hi_cyc, d_cyc, d_bad;
  mct_counter dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .din(din), .dout(dout), .counter_output(counter_output));
  mct_ext_sig ext_u (.sys_clk(sys_clk), .din(din));
  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    if (counter_output === 1'b1) hi_cyc <= hi_cyc + 1;
    if (dout === 8'h05) d_cyc <= d_cyc + 1;
    if ((dout & 8'hfa) !== 8'h00) d_bad <= d_bad + 1;
    if (cyc == 20000)
    begin
      bad_count++;
      close_out;
    end
  end
  task automatic close_out;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] r, output logic e);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    xfer(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    logic e;
    xfer(1'b0, a, 32'h0, r, e);
  endtask
  task automatic wait_st(input logic [1:0] s);
    logic [31:0] r;
    int n;
    n = 0;
    rd(`MCT_OFF_STATUS, r);
    while (r[1:0] !== s && n < 60)
    begin
      rd(`MCT_OFF_STATUS, r);
      n++;
    end
    chk("state", {30'h0, r[1:0]}, {30'h0, s});
  endtask
  function automatic logic [31:0] mk(mct_pkg::mct_mode_t m, mct_pkg::mct_end_t e, logic au);
    mct_pkg::mct_ctrl_t c;
    c = '0;
    c.mode = m;
    c.end_sel = e;
    c.launch_select = au;
    c.enable = 1'b1;
    mk = {17'h0, c};
  endfunction
  task automatic t_regs;
    logic [31:0] r;
    logic e;
    rd(`MCT_OFF_COUNT, r);
    chk("count_rst", r, 32'h0);
    wr(`MCT_OFF_LOAD, 32'hdead_beef);
    rd(`MCT_OFF_LOAD, r);
    chk("load", r, 32'hdead_beef);
    xfer(1'b0, 8'h44, 32'h0, r, e);
    chk("unmapped", r, 32'h0);
    chk("slverr", {31'h0, e}, 32'h1);
    $display("done regs");
  endtask
  // second call with new limits must give a new high time
  task automatic t_timer(input logic [31:0] lo, input logic [31:0] hi, input logic [31:0] dv);
    logic [31:0] r;
    int h0, d0;
    wr(`MCT_OFF_CTRL, 32'h0);
    wr(`MCT_OFF_LOAD, 32'h0);
    wr(`MCT_OFF_CMP_LO, lo);
    wr(`MCT_OFF_CMP_HI, hi);
    wr(`MCT_OFF_DIV, dv);
    wr(`MCT_OFF_OUTEN, 32'h5);
    h0 = hi_cyc;
    d0 = d_cyc;
    wr(`MCT_OFF_CTRL, mk(mct_pkg::MCT_M_TIMER, mct_pkg::MCT_E_CMP_HI, 1'b1));
    wait_st(2'b10);
    repeat (3) @(posedge sys_clk);
    chk("hi_len", hi_cyc - h0, (hi - lo) * (dv + 1));
    chk("pin_len", d_cyc - d0, (hi - lo) * (dv + 1));
    chk("pin_mask", d_bad, 32'h0);
    rd(`MCT_OFF_COUNT, r);
    chk("end_cnt", r, hi);
    $display("done timer");
  endtask
  task automatic t_start;
    logic [31:0] r;
    wr(`MCT_OFF_CTRL, 32'h0);
    wr(`MCT_OFF_LOAD, 32'h20);
    wr(`MCT_OFF_CTRL, mk(mct_pkg::MCT_M_TIMER, mct_pkg::MCT_E_NONE, 1'b0));
    wr(`MCT_OFF_CMD, 32'h2);
    rd(`MCT_OFF_COUNT, r);
    chk("clr_idle", r, 32'h20);
    rd(`MCT_OFF_STATUS, r);
    chk("no_auto", {30'h0, r[1:0]}, 32'h0);
    wr(`MCT_OFF_CMD, 32'h1);
    wait_st(2'b11);
    repeat (20) @(posedge sys_clk);
    wr(`MCT_OFF_CMD, 32'h2);
    rd(`MCT_OFF_COUNT, r);
    chk("clr_run", {31'h0, r >= 32'h20 && r <= 32'h24}, 32'h1);
    $display("done start");
  endtask
  task automatic t_event;
    logic [31:0] r;
    wr(`MCT_OFF_CTRL, 32'h0);
    wr(`MCT_OFF_PINSEL, 32'h0503);
    wr(`MCT_OFF_DB_CNT, 32'h3);
    wr(`MCT_OFF_LOAD, 32'h100);
    wr(`MCT_OFF_CTRL, mk(mct_pkg::MCT_M_EVENT, mct_pkg::MCT_E_NONE, 1'b1));
    repeat (4) @(posedge sys_clk);
    repeat (4) ext_u.pulse(8, 8);
    ext_u.pulse(2, 8);
    rd(`MCT_OFF_COUNT, r);
    chk("events", r, 32'h104);
    $display("done event");
  endtask
  task automatic t_quad;
    logic [31:0] r;
    wr(`MCT_OFF_CTRL, 32'h0);
    wr(`MCT_OFF_DB_CNT, 32'h0);
    wr(`MCT_OFF_DB_CTL, 32'h0);
    ext_u.set_ctl(1'b1);
    wr(`MCT_OFF_CTRL, mk(mct_pkg::MCT_M_QUAD, mct_pkg::MCT_E_NONE, 1'b1));
    repeat (4) @(posedge sys_clk);
    repeat (3) ext_u.pulse(4, 4);
    ext_u.set_ctl(1'b0);
    repeat (4) @(posedge sys_clk);
    repeat (2) ext_u.pulse(4, 4);
    repeat (4) @(posedge sys_clk);
    rd(`MCT_OFF_COUNT, r);
    chk("quad", r, 32'h101);
    $display("done quad");
  endtask
  task automatic t_half;
    logic [31:0] r;
    wr(`MCT_OFF_CTRL, 32'h0);
    wr(`MCT_OFF_LOAD, 32'h0);
    wr(`MCT_OFF_CTRL, mk(mct_pkg::MCT_M_HALF, mct_pkg::MCT_E_NONE, 1'b1));
    repeat (4) @(posedge sys_clk);
    ext_u.pulse(20, 8);
    rd(`MCT_OFF_COUNT, r);
    chk("half", r, 32'd20);
    $display("done half");
  endtask
  // ctrl bits: 7 trigger, 8 auto clear, 9 gating, 10 loop, 11 to 13 invert count, control, output
  task automatic t_train;
    int h0;
    wr(`MCT_OFF_CTRL, 32'h0);
    wr(`MCT_OFF_LOAD, 32'h0);
    wr(`MCT_OFF_DIV, 32'h0);
    wr(`MCT_OFF_CMP_LO, 32'h2);
    wr(`MCT_OFF_CMP_HI, 32'h5);
    wr(`MCT_OFF_PULSES, 32'h3);
    h0 = hi_cyc;
    wr(`MCT_OFF_CTRL, mk(mct_pkg::MCT_M_TIMER, mct_pkg::MCT_E_CMP_HI, 1'b1) | 32'h400);
    wait_st(2'b10);
    chk("train_hi", hi_cyc - h0, 32'd9);
    $display("done train");
  endtask
  task automatic t_trig;
    logic [31:0] r;
    int h0;
    wr(`MCT_OFF_CTRL, 32'h0);
    wr(`MCT_OFF_PULSES, 32'h0);
    wr(`MCT_OFF_LOAD, 32'h10);
    wr(`MCT_OFF_CMP_LO, 32'h10);
    wr(`MCT_OFF_CMP_HI, 32'h14);
    ext_u.set_ctl(1'b0);
    h0 = hi_cyc;
    wr(`MCT_OFF_CTRL, mk(mct_pkg::MCT_M_TIMER, mct_pkg::MCT_E_CMP_HI, 1'b1) | 32'h180);
    repeat (6) @(posedge sys_clk);
    rd(`MCT_OFF_STATUS, r);
    chk("trig_wait", {30'h0, r[1:0]}, 32'h1);
    ext_u.set_ctl(1'b1);
    repeat (12) @(posedge sys_clk);
    chk("trig_hi", hi_cyc - h0, 32'd4);
    rd(`MCT_OFF_STATUS, r);
    chk("reclear_st", {30'h0, r[1:0]}, 32'h1);
    rd(`MCT_OFF_COUNT, r);
    chk("reclear_cnt", r, 32'h10);
    $display("done trigger");
  endtask
  // gate pin high for eleven cycles gives eleven counts
  task automatic t_gate;
    logic [31:0] r;
    wr(`MCT_OFF_CTRL, 32'h0);
    wr(`MCT_OFF_LOAD, 32'h0);
    ext_u.set_ctl(1'b0);
    wr(`MCT_OFF_CTRL, mk(mct_pkg::MCT_M_TIMER, mct_pkg::MCT_E_NONE, 1'b1) | 32'h200);
    repeat (4) @(posedge sys_clk);
    rd(`MCT_OFF_COUNT, r);
    chk("gate_off", r, 32'h0);
    ext_u.set_ctl(1'b1);
    repeat (10) @(posedge sys_clk);
    ext_u.set_ctl(1'b0);
    repeat (4) @(posedge sys_clk);
    rd(`MCT_OFF_COUNT, r);
    chk("gate_on", r, 32'd11);
    $display("done gate");
  endtask
  // three edges eight clocks apart: two periods, sixteen clocks
  task automatic t_meas;
    logic [31:0] r;
    wr(`MCT_OFF_CTRL, 32'h0);
    wr(`MCT_OFF_TBASE, 32'd40);
    wr(`MCT_OFF_CTRL, mk(mct_pkg::MCT_M_TPM, mct_pkg::MCT_E_TBASE, 1'b1));
    repeat (3) ext_u.pulse(4, 4);
    wait_st(2'b10);
    rd(`MCT_OFF_EDGES, r);
    chk("tpm_edges", r, 32'h3);
    rd(`MCT_OFF_SPAN, r);
    chk("tpm_span", r, 32'd16);
    wr(`MCT_OFF_CTRL, 32'h0);
    wr(`MCT_OFF_TALLY, 32'h3);
    wr(`MCT_OFF_CTRL, mk(mct_pkg::MCT_M_NPER, mct_pkg::MCT_E_TALLY, 1'b1));
    repeat (3) ext_u.pulse(4, 4);
    wait_st(2'b10);
    rd(`MCT_OFF_COUNT, r);
    chk("nper_clks", r, 32'd16);
    $display("done measure");
  endtask
  task automatic t_inv;
    logic [31:0] r;
    wr(`MCT_OFF_CTRL, 32'h3800);
    repeat (4) @(posedge sys_clk);
    rd(`MCT_OFF_STATUS, r);
    chk("invert", {29'h0, r[4:2]}, 32'h7);
    chk("invert_pin", {31'h0, counter_output}, 32'h1);
    $display("done invert");
  endtask
  initial
  begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_regs;
    t_timer(32'h4, 32'ha, 32'h1);
    t_timer(32'h7, 32'ha, 32'h0);
    t_start;
    t_event;
    t_quad;
    t_half;
    t_train;
    t_trig;
    t_gate;
    t_meas;
    t_inv;
    close_out;
  end
endmodule // tb
`default_nettype wire

// ==== src/mct_counter.sv ====
// The implementer's own choices: register access over APB and the register addresses.
`include "mct_params.svh"
`default_nettype none
//Contract
// - timer mode counts reference clock cycles, divided when divider is nonzero.
// - output low from load value to low limit, high until high limit.
// - end condition choice makes timer a bin counter or one-shot.
// - event mode counts debounced count_input edges instead of the clock.
// - period measurement counts input edges and clocks from first to last edge.
// - half-period mode counts clock cycles while count_input is high.
// - N-period mode counts clocks until tally minus one periods elapse.
// - quadrature mode counts input edges up when control high, down when low.
// - hardware trigger available in every mode but quadrature.
// - counting ends on the selected termination condition.
// - launch_select picks automatic start or explicit start command.
// - clear command reloads counter with initial_load_value.
// - inputs must stay stable for their debounce times before changing.
// - auto_clear_on_finish clears counter at finish and awaits next trigger.
// - gating counts only while control_input enables, when not a trigger.
// - loop_after_finish restarts counter after termination.
// - selectable pins feed the inputs; output drives selected pins.
// - new compare limits change the output waveform.
// - pulse train emits configured pulse count then stops.
module mct_counter #(
  parameter int N_PINS = 8,
  parameter int SELW = 3
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [N_PINS-1:0] din,
  output logic [N_PINS-1:0] dout,
  output logic counter_output
);
  mct_pkg::mct_ctrl_t ctrl_q;
  mct_pkg::mct_state_t state_q;
  logic [31:0] load_q, cmp_lo_q, cmp_hi_q, div_q, tally_q, tbase_q, dbt_q [2];
  logic [31:0] pinsel_q, outen_q, pulses_q;
  logic [31:0] count_q, div_cnt_q, pc_q, tb_q, edges_q, span_q, rem_q;
  logic [31:0] prdata_q;
  logic pslverr_q, seen_q, out_q;
  logic [N_PINS-1:0] dout_q;
  logic [1:0] raw, db_q, prev_q;
  logic [31:0] dbc_q [2];
  logic wr, rd_setup, start_cmd, clr_cmd, cin, ctl, cin_rise, ctl_rise, ctl_fall;
  logic run, gate_ok, tick, term, fin, go_arm, go_run, uses_trig, last_pulse, out_d;

  assign wr = psel & penable & pwrite;
  assign rd_setup = psel & ~penable;
  assign pready = penable;
  assign prdata = prdata_q;
  assign pslverr = pslverr_q;
  assign start_cmd = wr && paddr == `MCT_OFF_CMD && pwdata[`MCT_CMD_START];
  assign clr_cmd = wr && paddr == `MCT_OFF_CMD && pwdata[`MCT_CMD_CLEAR];

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_q <= '0;
      load_q <= `MCT_RST_WORD;
      cmp_lo_q <= `MCT_RST_WORD;
      cmp_hi_q <= `MCT_RST_WORD;
      div_q <= `MCT_RST_WORD;
      tally_q <= `MCT_RST_WORD;
      tbase_q <= `MCT_RST_WORD;
      dbt_q[0] <= `MCT_RST_WORD;
      dbt_q[1] <= `MCT_RST_WORD;
      pinsel_q <= `MCT_RST_WORD;
      outen_q <= `MCT_RST_WORD;
      pulses_q <= `MCT_RST_WORD;
    end
    else if (wr)
    begin
      case (paddr)
        `MCT_OFF_CTRL: ctrl_q <= mct_pkg::mct_ctrl_t'(pwdata[$bits(mct_pkg::mct_ctrl_t)-1:0]);
        `MCT_OFF_LOAD: load_q <= pwdata;
        `MCT_OFF_CMP_LO: cmp_lo_q <= pwdata;
        `MCT_OFF_CMP_HI: cmp_hi_q <= pwdata;
        `MCT_OFF_DIV: div_q <= pwdata;
        `MCT_OFF_TALLY: tally_q <= pwdata;
        `MCT_OFF_TBASE: tbase_q <= pwdata;
        `MCT_OFF_DB_CNT: dbt_q[0] <= pwdata;
        `MCT_OFF_DB_CTL: dbt_q[1] <= pwdata;
        `MCT_OFF_PINSEL: pinsel_q <= pwdata;
        `MCT_OFF_OUTEN: outen_q <= pwdata;
        `MCT_OFF_PULSES: pulses_q <= pwdata;
        default: ;
      endcase
    end
  end

  // read data captured in setup so the access phase answers with no wait state
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prdata_q <= `MCT_RST_WORD;
      pslverr_q <= 1'b0;
    end
    else if (rd_setup)
    begin
      pslverr_q <= 1'b0;
      case (paddr)
        `MCT_OFF_CTRL: prdata_q <= 32'(ctrl_q);
        `MCT_OFF_CMD: prdata_q <= `MCT_RST_WORD;
        `MCT_OFF_LOAD: prdata_q <= load_q;
        `MCT_OFF_CMP_LO: prdata_q <= cmp_lo_q;
        `MCT_OFF_CMP_HI: prdata_q <= cmp_hi_q;
        `MCT_OFF_DIV: prdata_q <= div_q;
        `MCT_OFF_TALLY: prdata_q <= tally_q;
        `MCT_OFF_TBASE: prdata_q <= tbase_q;
        `MCT_OFF_DB_CNT: prdata_q <= dbt_q[0];
        `MCT_OFF_DB_CTL: prdata_q <= dbt_q[1];
        `MCT_OFF_COUNT: prdata_q <= count_q;
        `MCT_OFF_STATUS: prdata_q <= {27'h0, db_q, counter_output, state_q};
        `MCT_OFF_EDGES: prdata_q <= edges_q;
        `MCT_OFF_SPAN: prdata_q <= span_q;
        `MCT_OFF_PINSEL: prdata_q <= pinsel_q;
        `MCT_OFF_OUTEN: prdata_q <= outen_q;
        `MCT_OFF_PULSES: prdata_q <= pulses_q;
        default:
        begin
          prdata_q <= `MCT_RST_WORD;
          pslverr_q <= 1'b1;
        end
      endcase
    end
  end

  assign raw[0] = din[pinsel_q[SELW-1:0]] ^ ctrl_q.invert_count_input;
  assign raw[1] = din[pinsel_q[`MCT_PIN_CTL_LSB +: SELW]] ^ ctrl_q.invert_control_input;

  // a change is taken only after holding for the programmed number of cycles
  for (genvar i = 0; i < 2; i++)
  begin : g_deb
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        db_q[i] <= 1'b0;
        dbc_q[i] <= `MCT_RST_WORD;
        prev_q[i] <= 1'b0;
      end
      else
      begin
        prev_q[i] <= db_q[i];
        if (raw[i] == db_q[i])
          dbc_q[i] <= `MCT_RST_WORD;
        else if (dbc_q[i] >= dbt_q[i])
        begin
          db_q[i] <= raw[i];
          dbc_q[i] <= `MCT_RST_WORD;
        end
        else
          dbc_q[i] <= dbc_q[i] + 32'h1;
      end
    end
  end

  assign cin = db_q[0];
  assign ctl = db_q[1];
  assign cin_rise = db_q[0] & ~prev_q[0];
  assign ctl_rise = db_q[1] & ~prev_q[1];
  assign ctl_fall = ~db_q[1] & prev_q[1];
  assign run = state_q == mct_pkg::MCT_S_RUN;
  assign gate_ok = !(ctrl_q.gating && !ctrl_q.trigger_from_control) || ctl;
  assign uses_trig = ctrl_q.trigger_from_control && ctrl_q.mode != mct_pkg::MCT_M_QUAD;
  assign go_arm = state_q == mct_pkg::MCT_S_IDLE && ctrl_q.enable && (ctrl_q.launch_select || start_cmd);
  assign go_run = state_q == mct_pkg::MCT_S_ARMED && (!uses_trig || ctl_rise);
  assign last_pulse = pulses_q != `MCT_RST_WORD && rem_q <= 32'h1;

  always_comb
  begin
    tick = 1'b0;
    case (ctrl_q.mode)
      mct_pkg::MCT_M_EVENT: tick = cin_rise;
      mct_pkg::MCT_M_TPM: tick = seen_q || cin_rise;
      mct_pkg::MCT_M_HALF: tick = cin;
      // the first edge only opens the window, else one clock too many is counted
      mct_pkg::MCT_M_NPER: tick = seen_q;
      mct_pkg::MCT_M_QUAD: tick = cin_rise;
      default: tick = div_cnt_q >= div_q;
    endcase
  end

  always_comb
  begin
    term = 1'b0;
    case (ctrl_q.end_sel)
      mct_pkg::MCT_E_CMP_LO: term = count_q == cmp_lo_q;
      mct_pkg::MCT_E_CMP_HI: term = count_q == cmp_hi_q;
      mct_pkg::MCT_E_MAX: term = count_q == `MCT_MAX_COUNT;
      mct_pkg::MCT_E_TALLY: term = pc_q == `MCT_RST_WORD;
      mct_pkg::MCT_E_TBASE: term = tb_q == `MCT_RST_WORD;
      mct_pkg::MCT_E_CTL_FALL: term = ctl_fall;
      default: term = 1'b0;
    endcase
  end
  assign fin = run && term;

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      state_q <= mct_pkg::MCT_S_IDLE;
    else if (!ctrl_q.enable)
      state_q <= mct_pkg::MCT_S_IDLE;
    else if (go_arm)
      state_q <= mct_pkg::MCT_S_ARMED;
    else if (go_run)
      state_q <= mct_pkg::MCT_S_RUN;
    else if (fin)
    begin
      if (ctrl_q.loop_after_finish && !last_pulse)
        state_q <= mct_pkg::MCT_S_RUN;
      else if (ctrl_q.auto_clear_on_finish && !last_pulse)
        state_q <= mct_pkg::MCT_S_ARMED;
      else
        state_q <= mct_pkg::MCT_S_DONE;
    end
    else if (state_q == mct_pkg::MCT_S_DONE && start_cmd)
      state_q <= mct_pkg::MCT_S_ARMED;
  end

  // prescaler only free-runs while counting, so the first divided tick is a full period
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      div_cnt_q <= `MCT_RST_WORD;
    else if (!run || div_cnt_q >= div_q)
      div_cnt_q <= `MCT_RST_WORD;
    else
      div_cnt_q <= div_cnt_q + 32'h1;
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      count_q <= `MCT_RST_WORD;
    else if (clr_cmd || go_run)
      count_q <= load_q;
    else if (fin)
    begin
      if (ctrl_q.loop_after_finish || ctrl_q.auto_clear_on_finish)
        count_q <= load_q;
    end
    else if (run && gate_ok && tick)
    begin
      if (ctrl_q.mode == mct_pkg::MCT_M_QUAD && !ctl)
        count_q <= count_q - 32'h1;
      else
        count_q <= count_q + 32'h1;
    end
  end

  // period and timebase counters, plus edge tally and first-to-last-edge span
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pc_q <= `MCT_RST_WORD;
      tb_q <= `MCT_RST_WORD;
      edges_q <= `MCT_RST_WORD;
      span_q <= `MCT_RST_WORD;
      seen_q <= 1'b0;
    end
    else if (go_run || (fin && ctrl_q.loop_after_finish))
    begin
      pc_q <= ctrl_q.mode == mct_pkg::MCT_M_NPER ? tally_q - 32'h1 : tally_q;
      tb_q <= tbase_q;
      edges_q <= `MCT_RST_WORD;
      span_q <= `MCT_RST_WORD;
      seen_q <= 1'b0;
    end
    else if (run && gate_ok)
    begin
      if (tb_q != `MCT_RST_WORD)
        tb_q <= tb_q - 32'h1;
      if (cin_rise)
      begin
        seen_q <= 1'b1;
        edges_q <= edges_q + 32'h1;
        span_q <= count_q - load_q;
        if (seen_q && pc_q != `MCT_RST_WORD)
          pc_q <= pc_q - 32'h1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      rem_q <= `MCT_RST_WORD;
    else if (go_arm || (state_q == mct_pkg::MCT_S_DONE && start_cmd))
      rem_q <= pulses_q;
    else if (fin && rem_q != `MCT_RST_WORD)
      rem_q <= rem_q - 32'h1;
  end

  assign out_d = ((run || state_q == mct_pkg::MCT_S_DONE) && count_q >= cmp_lo_q && count_q < cmp_hi_q)
    ^ ctrl_q.invert_counter_output;

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      out_q <= 1'b0;
      dout_q <= '0;
    end
    else
    begin
      out_q <= out_d;
      dout_q <= outen_q[N_PINS-1:0] & {N_PINS{out_d}};
    end
  end
  assign counter_output = out_q;
  assign dout = dout_q;

  a_clear_reload: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clr_cmd |=> count_q == $past(load_q)) else $error("clear did not reload");
  a_out_low_below: assert property (@(posedge sys_clk) disable iff (!rst_n)
    run && count_q < cmp_lo_q && !ctrl_q.invert_counter_output |=> !counter_output)
    else $error("output high below low limit");
  a_timer_step: assert property (@(posedge sys_clk) disable iff (!rst_n)
    run && ctrl_q.mode == mct_pkg::MCT_M_TIMER && div_q == `MCT_RST_WORD && gate_ok && !fin && !clr_cmd
    && !wr |=> count_q == $past(count_q) + 32'h1) else $error("timer did not step");
  a_quad_down: assert property (@(posedge sys_clk) disable iff (!rst_n)
    run && ctrl_q.mode == mct_pkg::MCT_M_QUAD && cin_rise && !ctl && gate_ok && !fin && !clr_cmd && !wr
    |=> count_q == $past(count_q) - 32'h1) else $error("quadrature did not count down");
  a_fin_stops: assert property (@(posedge sys_clk) disable iff (!rst_n)
    fin && !ctrl_q.loop_after_finish && !ctrl_q.auto_clear_on_finish && ctrl_q.enable && !wr
    |=> state_q == mct_pkg::MCT_S_DONE ##1 state_q != mct_pkg::MCT_S_RUN)
    else $error("no stop on termination");
  a_auto_clear: assert property (@(posedge sys_clk) disable iff (!rst_n)
    fin && ctrl_q.auto_clear_on_finish && !ctrl_q.loop_after_finish && !last_pulse && ctrl_q.enable && !wr
    |=> state_q == mct_pkg::MCT_S_ARMED && count_q == load_q) else $error("auto clear failed");
  a_trig_wait: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state_q == mct_pkg::MCT_S_ARMED && uses_trig && !ctl_rise && !wr |=> state_q != mct_pkg::MCT_S_RUN)
    else $error("ran without trigger");
  a_deb_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
    raw[0] != db_q[0] && dbc_q[0] < dbt_q[0] |=> db_q[0] == $past(db_q[0]))
    else $error("input accepted before debounce time");
  a_gate_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
    run && ctrl_q.gating && !ctrl_q.trigger_from_control && !ctl && !fin && !clr_cmd && !wr
    |=> count_q == $past(count_q)) else $error("counted while gated off");
  c_loop: cover property (@(posedge sys_clk) disable iff (!rst_n) fin && ctrl_q.loop_after_finish);
  c_train_done: cover property (@(posedge sys_clk) disable iff (!rst_n) fin && last_pulse);
  c_trig_start: cover property (@(posedge sys_clk) disable iff (!rst_n) go_run && uses_trig);
  c_nper_done: cover property (@(posedge sys_clk) disable iff (!rst_n) fin && ctrl_q.mode == mct_pkg::MCT_M_NPER);
  c_gate_block: cover property (@(posedge sys_clk) disable iff (!rst_n) run && !gate_ok);
  // register writes are left out of all but a_clear_reload, a_out_low_below, a_deb_hold, a_out_high_mid
  // and a_tally_load: a reconfigured channel may legally jump anywhere
  a_out_high_mid: assert property (@(posedge sys_clk) disable iff (!rst_n)
    run && count_q >= cmp_lo_q && count_q < cmp_hi_q && !ctrl_q.invert_counter_output |=> counter_output)
    else $error("output low between limits");
  a_loop_restart: assert property (@(posedge sys_clk) disable iff (!rst_n)
    fin && ctrl_q.loop_after_finish && !last_pulse && ctrl_q.enable && !wr
    |=> state_q == mct_pkg::MCT_S_RUN && count_q == $past(load_q)) else $error("loop did not restart");
  a_train_stop: assert property (@(posedge sys_clk) disable iff (!rst_n)
    fin && last_pulse && ctrl_q.enable && !wr |=> state_q == mct_pkg::MCT_S_DONE) else $error("train overran");
  a_tally_load: assert property (@(posedge sys_clk) disable iff (!rst_n)
    go_run && ctrl_q.mode == mct_pkg::MCT_M_NPER |=> pc_q == $past(tally_q) - 32'h1)
    else $error("period tally not loaded");
  a_nper_window: assert property (@(posedge sys_clk) disable iff (!rst_n)
    run && ctrl_q.mode == mct_pkg::MCT_M_NPER && !seen_q && !fin && !clr_cmd && !wr
    |=> count_q == $past(count_q)) else $error("counted before first edge");
  a_half_level: assert property (@(posedge sys_clk) disable iff (!rst_n)
    run && ctrl_q.mode == mct_pkg::MCT_M_HALF && !cin && !fin && !clr_cmd && !wr
    |=> count_q == $past(count_q)) else $error("counted while input low");
  a_quad_notrig: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state_q == mct_pkg::MCT_S_ARMED && ctrl_q.mode == mct_pkg::MCT_M_QUAD && ctrl_q.enable && !wr
    |=> state_q == mct_pkg::MCT_S_RUN) else $error("quadrature waited for trigger");
endmodule // mct_counter
`default_nettype wire

// ==== src/mct_params.svh ====
`ifndef MCT_PARAMS_SVH
`define MCT_PARAMS_SVH
`define MCT_OFF_CTRL 8'h00
`define MCT_OFF_CMD 8'h04
`define MCT_OFF_LOAD 8'h08
`define MCT_OFF_CMP_LO 8'h0c
`define MCT_OFF_CMP_HI 8'h10
`define MCT_OFF_DIV 8'h14
`define MCT_OFF_TALLY 8'h18
`define MCT_OFF_TBASE 8'h1c
`define MCT_OFF_DB_CNT 8'h20
`define MCT_OFF_DB_CTL 8'h24
`define MCT_OFF_COUNT 8'h28
`define MCT_OFF_STATUS 8'h2c
`define MCT_OFF_EDGES 8'h30
`define MCT_OFF_SPAN 8'h34
`define MCT_OFF_PINSEL 8'h38
`define MCT_OFF_OUTEN 8'h3c
`define MCT_OFF_PULSES 8'h40
`define MCT_CMD_START 0
`define MCT_CMD_CLEAR 1
`define MCT_PIN_CTL_LSB 8
`define MCT_MAX_COUNT 32'h0fffffff
`define MCT_RST_WORD 32'h0000_0000
`endif

// ==== src/mct_pkg.sv ====
`default_nettype none
package mct_pkg;
  typedef enum logic [2:0] {
    MCT_M_TIMER = 3'h0,
    MCT_M_EVENT = 3'h1,
    MCT_M_TPM = 3'h2,
    MCT_M_HALF = 3'h3,
    MCT_M_NPER = 3'h4,
    MCT_M_QUAD = 3'h5
  } mct_mode_t;
  typedef enum logic [2:0] {
    MCT_E_CMP_LO = 3'h0,
    MCT_E_CMP_HI = 3'h1,
    MCT_E_MAX = 3'h2,
    MCT_E_TALLY = 3'h3,
    MCT_E_TBASE = 3'h4,
    MCT_E_CTL_FALL = 3'h5,
    MCT_E_NONE = 3'h6
  } mct_end_t;
  typedef enum logic [1:0] {
    MCT_S_IDLE = 2'b00,
    MCT_S_ARMED = 2'b01,
    MCT_S_RUN = 2'b11,
    MCT_S_DONE = 2'b10
  } mct_state_t;
  typedef struct packed {
    logic enable;
    logic invert_counter_output;
    logic invert_control_input;
    logic invert_count_input;
    logic loop_after_finish;
    logic gating;
    logic auto_clear_on_finish;
    logic trigger_from_control;
    logic launch_select;
    mct_end_t end_sel;
    mct_mode_t mode;
  } mct_ctrl_t;
endpackage
`default_nettype wire
